//--- src/ssd_map.svh
// Overview of operation
// - Five subtract-with-borrow forms are recognised, each issuing in one clock, hit or miss.
// - 0F 92 with reg field 000 sets byte when carry is set.
// - 0F 96 with reg field 000 sets byte when carry or zero set.
// - 0F 94 with reg field 000 sets byte when zero is set.
// - 0F 9C with reg field 000 sets byte when sign differs from overflow.
// - 0F 9E with reg field 000 sets byte when zero, or sign differs overflow.
// - 0F 93 with reg field 000 sets byte when carry is clear.
// - 0F 97 with reg field 000 sets byte when carry and zero clear.
// - 0F 95 with reg field 000 sets byte when zero is clear.
// - 0F 9D with reg field 000 sets byte when sign equals overflow.
// - 0F 9F with reg field 000 sets byte when zero clear, sign equals overflow.
// - 0F 91 with reg field 000 sets byte when overflow is clear.
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH

// First byte of two-byte opcodes
`define SSD_ESC_0F 8'h0F
// Second bytes of the set-byte family
`define SSD_OP_NO 8'h91
`define SSD_OP_B 8'h92
`define SSD_OP_NB 8'h93
`define SSD_OP_E 8'h94
`define SSD_OP_NE 8'h95
`define SSD_OP_BE 8'h96
`define SSD_OP_A 8'h97
`define SSD_OP_L 8'h9C
`define SSD_OP_GE 8'h9D
`define SSD_OP_LE 8'h9E
`define SSD_OP_G 8'h9F
// Subtract-with-borrow opcode patterns
`define SSD_MASK_DW 8'hFC
`define SSD_MASK_W 8'hFE
`define SSD_BORROW_RM 8'h18
`define SSD_BORROW_ACC 8'h1C
`define SSD_GRP_IMM 8'h80
// Opcode and ModRM field positions
`define SSD_D_BIT 1
`define SSD_MOD_HI 7
`define SSD_MOD_LO 6
`define SSD_REG_HI 5
`define SSD_REG_LO 3
// ModRM field values
`define SSD_MOD_REG 2'h3
`define SSD_REG_BORROW 3'h3
`define SSD_REG_SET 3'h0
// Issue timing and set-byte results
`define SSD_ISSUE_CLK 4'h1
`define SSD_BYTE_TRUE 8'h01
`define SSD_BYTE_FALSE 8'h00

`endif

//--- src/ssd_pkg.sv
package ssd_pkg;

  typedef enum logic [4:0] {
    op_none,
    op_subtract_with_borrow_rr,
    op_subtract_with_borrow_rm,
    op_subtract_with_borrow_mr,
    op_subtract_with_borrow_imm,
    op_subtract_with_borrow_acc,
    op_set_byte_below,
    op_set_byte_below_or_equal,
    op_set_byte_equal,
    op_set_byte_less,
    op_set_byte_less_or_equal,
    op_set_byte_not_below,
    op_set_byte_above,
    op_set_byte_not_equal,
    op_set_byte_greater_or_equal,
    op_set_byte_greater,
    op_set_byte_no_overflow
  } ssd_op_e;

  typedef struct packed {
    logic [7:0] op0;
    logic [7:0] op1;
    logic [7:0] modrm;
  } ssd_insn_s;

  typedef struct packed {
    logic of_f;
    logic sf;
    logic zf;
    logic cf;
  } ssd_flags_s;

  typedef struct packed {
    ssd_op_e op;
    logic [3:0] issue_clks;
    logic mem_dest;
    logic writes_flags;
    logic set_write;
    logic [7:0] set_value;
  } ssd_dec_s;

endpackage

//--- src/ssd_decode.sv
`timescale 1ns/100ps
`include "ssd_map.svh"

module ssd_decode (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Instruction from fetch
  input wire logic in_valid,
  input wire ssd_pkg::ssd_insn_s insn,
  input wire logic cache_hit,
  // Current arithmetic flags
  input wire ssd_pkg::ssd_flags_s flags,
  // Decode result
  output logic out_valid,
  output ssd_pkg::ssd_dec_s dec,
  output logic hit,
  output logic unrecognised
);

  // Register target when mod is 11
  function automatic logic reg_target(logic [7:0] m);
    reg_target = (m[`SSD_MOD_HI:`SSD_MOD_LO] == `SSD_MOD_REG);
  endfunction

  function automatic ssd_pkg::ssd_op_e decode_op(ssd_pkg::ssd_insn_s i);
    logic [2:0] rf;
    logic reg_mode;
    rf = i.modrm[`SSD_REG_HI:`SSD_REG_LO];
    reg_mode = reg_target(i.modrm);
    decode_op = ssd_pkg::op_none;
    if (i.op0 == `SSD_ESC_0F) begin
      if (rf == `SSD_REG_SET) begin
        case (i.op1)
          `SSD_OP_B: decode_op = ssd_pkg::op_set_byte_below;
          `SSD_OP_BE: decode_op = ssd_pkg::op_set_byte_below_or_equal;
          `SSD_OP_E: decode_op = ssd_pkg::op_set_byte_equal;
          `SSD_OP_L: decode_op = ssd_pkg::op_set_byte_less;
          `SSD_OP_LE: decode_op = ssd_pkg::op_set_byte_less_or_equal;
          `SSD_OP_NB: decode_op = ssd_pkg::op_set_byte_not_below;
          `SSD_OP_A: decode_op = ssd_pkg::op_set_byte_above;
          `SSD_OP_NE: decode_op = ssd_pkg::op_set_byte_not_equal;
          `SSD_OP_GE: decode_op = ssd_pkg::op_set_byte_greater_or_equal;
          `SSD_OP_G: decode_op = ssd_pkg::op_set_byte_greater;
          `SSD_OP_NO: decode_op = ssd_pkg::op_set_byte_no_overflow;
          default: decode_op = ssd_pkg::op_none;
        endcase
      end
    end else if ((i.op0 & `SSD_MASK_DW) == `SSD_BORROW_RM) begin
      if (reg_mode) begin
        decode_op = ssd_pkg::op_subtract_with_borrow_rr;
      end else if (i.op0[`SSD_D_BIT]) begin
        decode_op = ssd_pkg::op_subtract_with_borrow_mr;
      end else begin
        decode_op = ssd_pkg::op_subtract_with_borrow_rm;
      end
    end else if ((i.op0 & `SSD_MASK_W) == `SSD_BORROW_ACC) begin
      decode_op = ssd_pkg::op_subtract_with_borrow_acc;
    end else if ((i.op0 & `SSD_MASK_DW) == `SSD_GRP_IMM && rf == `SSD_REG_BORROW) begin
      decode_op = ssd_pkg::op_subtract_with_borrow_imm;
    end
  endfunction

  function automatic logic is_set_byte(ssd_pkg::ssd_op_e op);
    is_set_byte = (op >= ssd_pkg::op_set_byte_below);
  endfunction

  function automatic logic cond_true(ssd_pkg::ssd_op_e op, ssd_pkg::ssd_flags_s f);
    cond_true = 1'b0;
    unique case (op)
      ssd_pkg::op_set_byte_below: cond_true = f.cf;
      ssd_pkg::op_set_byte_below_or_equal: cond_true = f.cf | f.zf;
      ssd_pkg::op_set_byte_equal: cond_true = f.zf;
      ssd_pkg::op_set_byte_less: cond_true = f.sf ^ f.of_f;
      ssd_pkg::op_set_byte_less_or_equal: cond_true = f.zf | (f.sf ^ f.of_f);
      ssd_pkg::op_set_byte_not_below: cond_true = ~f.cf;
      ssd_pkg::op_set_byte_above: cond_true = ~(f.cf | f.zf);
      ssd_pkg::op_set_byte_not_equal: cond_true = ~f.zf;
      ssd_pkg::op_set_byte_greater_or_equal: cond_true = ~(f.sf ^ f.of_f);
      ssd_pkg::op_set_byte_greater: cond_true = ~f.zf & ~(f.sf ^ f.of_f);
      ssd_pkg::op_set_byte_no_overflow: cond_true = ~f.of_f;
      default: cond_true = 1'b0;
    endcase
  endfunction

  // Decode of the request in this cycle
  ssd_pkg::ssd_op_e next_op;
  ssd_pkg::ssd_dec_s next_dec;

  always_comb begin
    next_op = decode_op(insn);
    next_dec.op = next_op;
    next_dec.issue_clks = (next_op == ssd_pkg::op_none) ? 4'h0 : `SSD_ISSUE_CLK;
    // Memory target unless mod selects a register or the form is accumulator, memory to register or none
    next_dec.mem_dest = !reg_target(insn.modrm)
                        && next_op != ssd_pkg::op_subtract_with_borrow_acc
                        && next_op != ssd_pkg::op_subtract_with_borrow_mr
                        && next_op != ssd_pkg::op_none;
    // Set-byte leaves all flags alone
    next_dec.writes_flags = (next_op != ssd_pkg::op_none) && !is_set_byte(next_op);
    next_dec.set_write = is_set_byte(next_op);
    next_dec.set_value = cond_true(next_op, flags) ? `SSD_BYTE_TRUE : `SSD_BYTE_FALSE;
  end

  // Issue stage valid
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
    end
  end

  // Decoded result
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dec <= '0;
    end else if (in_valid) begin
      dec <= next_dec;
    end else begin
      dec <= '0;
    end
  end

  // Side status
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hit <= 1'b0;
      unrecognised <= 1'b0;
    end else begin
      hit <= in_valid & cache_hit;
      unrecognised <= in_valid && (next_op == ssd_pkg::op_none);
    end
  end

  // Set-byte request and its answer one cycle later
  sequence s_set_req(logic [7:0] opc);
    in_valid && insn.op0 == `SSD_ESC_0F && insn.op1 == opc
      && insn.modrm[`SSD_REG_HI:`SSD_REG_LO] == `SSD_REG_SET;
  endsequence

  sequence s_set_done(ssd_pkg::ssd_op_e kind, logic c);
    out_valid && dec.op == kind && dec.set_write && !dec.writes_flags
      && dec.issue_clks == 4'h1 && dec.set_value == (c ? 8'h01 : 8'h00);
  endsequence

  property p_set(logic [7:0] opc, ssd_pkg::ssd_op_e kind, logic c);
    @(posedge core_clk) disable iff (rst)
      s_set_req(opc) |=> s_set_done(kind, $past(c));
  endproperty

  // Subtract-with-borrow request and its answer
  sequence s_borrow_req(logic [7:0] mask, logic [7:0] pat);
    in_valid && (insn.op0 & mask) == pat;
  endsequence

  sequence s_borrow_done(ssd_pkg::ssd_op_e kind, logic md);
    out_valid && dec.op == kind && dec.writes_flags && !dec.set_write
      && dec.mem_dest == md && dec.issue_clks == 4'h1 && dec.set_value == 8'h00;
  endsequence

  // Set-byte request on any code of this block
  sequence s_set_any;
    in_valid && insn.op0 == 8'h0F && insn.modrm[5:3] == 3'h0
      && insn.op1 inside {8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97,
      8'h9C, 8'h9D, 8'h9E, 8'h9F};
  endsequence

  // Answer to a request with no opcode of this block
  sequence s_empty_ans;
    out_valid && unrecognised && dec == '0;
  endsequence

  // Subtract-with-borrow forms
  a_borrow_reg_reg: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && (insn.op0 & 8'hFC) == 8'h18 && insn.modrm[7:6] == 2'h3
    |=> out_valid && dec.op == ssd_pkg::op_subtract_with_borrow_rr && dec.issue_clks == 4'h1)
    else $error("register form of subtract-with-borrow misdecoded");
  a_borrow_imm_acc: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && (insn.op0 & 8'hFE) == 8'h1C
    |=> dec.op == ssd_pkg::op_subtract_with_borrow_acc && dec.writes_flags && !dec.mem_dest)
    else $error("accumulator form of subtract-with-borrow misdecoded");
  a_borrow_imm_grp: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && (insn.op0 & 8'hFC) == 8'h80 && insn.modrm[5:3] == 3'h3
    |=> dec.op == ssd_pkg::op_subtract_with_borrow_imm && dec.issue_clks == 4'h1)
    else $error("immediate form of subtract-with-borrow misdecoded");

  // Every subtract-with-borrow form, destination included
  a_borrow_rr_done: assert property (@(posedge core_clk) disable iff (rst)
    s_borrow_req(8'hFC, 8'h18) ##0 insn.modrm[7:6] == 2'h3
    |=> s_borrow_done(ssd_pkg::op_subtract_with_borrow_rr, 1'b0))
    else $error("register to register subtract-with-borrow wrong");
  a_borrow_reg_mem: assert property (@(posedge core_clk) disable iff (rst)
    s_borrow_req(8'hFE, 8'h18) ##0 insn.modrm[7:6] != 2'h3
    |=> s_borrow_done(ssd_pkg::op_subtract_with_borrow_rm, 1'b1))
    else $error("register to memory subtract-with-borrow wrong");
  a_borrow_mem_reg: assert property (@(posedge core_clk) disable iff (rst)
    s_borrow_req(8'hFE, 8'h1A) ##0 insn.modrm[7:6] != 2'h3
    |=> s_borrow_done(ssd_pkg::op_subtract_with_borrow_mr, 1'b0))
    else $error("memory to register subtract-with-borrow wrong");
  a_borrow_imm_dest: assert property (@(posedge core_clk) disable iff (rst)
    s_borrow_req(8'hFC, 8'h80) ##0 insn.modrm[5:3] == 3'h3
    |=> s_borrow_done(ssd_pkg::op_subtract_with_borrow_imm, $past(insn.modrm[7:6] != 2'h3)))
    else $error("immediate subtract-with-borrow destination wrong");
  a_borrow_acc_done: assert property (@(posedge core_clk) disable iff (rst)
    s_borrow_req(8'hFE, 8'h1C)
    |=> s_borrow_done(ssd_pkg::op_subtract_with_borrow_acc, 1'b0))
    else $error("accumulator subtract-with-borrow wrong");

  // One check per set-byte code
  a_set_below: assert property (p_set(8'h92, ssd_pkg::op_set_byte_below,
    flags.cf)) else $error("set byte below wrong");
  a_set_below_eq: assert property (p_set(8'h96, ssd_pkg::op_set_byte_below_or_equal,
    flags.cf | flags.zf)) else $error("set byte below or equal wrong");
  a_set_equal: assert property (p_set(8'h94, ssd_pkg::op_set_byte_equal,
    flags.zf)) else $error("set byte equal wrong");
  a_set_less: assert property (p_set(8'h9C, ssd_pkg::op_set_byte_less,
    flags.sf ^ flags.of_f)) else $error("set byte less wrong");
  a_set_less_eq: assert property (p_set(8'h9E, ssd_pkg::op_set_byte_less_or_equal,
    flags.zf | (flags.sf ^ flags.of_f))) else $error("set byte less or equal wrong");
  a_set_not_below: assert property (p_set(8'h93, ssd_pkg::op_set_byte_not_below,
    !flags.cf)) else $error("set byte not below wrong");
  a_set_above: assert property (p_set(8'h97, ssd_pkg::op_set_byte_above,
    !(flags.cf | flags.zf))) else $error("set byte above wrong");
  a_set_not_equal: assert property (p_set(8'h95, ssd_pkg::op_set_byte_not_equal,
    !flags.zf)) else $error("set byte not equal wrong");
  a_set_greater_eq: assert property (p_set(8'h9D, ssd_pkg::op_set_byte_greater_or_equal,
    flags.sf == flags.of_f)) else $error("set byte greater or equal wrong");
  a_set_greater: assert property (p_set(8'h9F, ssd_pkg::op_set_byte_greater,
    !flags.zf && flags.sf == flags.of_f)) else $error("set byte greater wrong");
  a_set_no_ovf: assert property (p_set(8'h91, ssd_pkg::op_set_byte_no_overflow,
    !flags.of_f)) else $error("set byte no overflow wrong");
  a_set_flags_kept: assert property (@(posedge core_clk) disable iff (rst)
    dec.set_write |-> !dec.writes_flags && dec.set_value inside {8'h00, 8'h01})
    else $error("set byte result or flag write wrong");
  a_set_reg_field: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && insn.op0 == 8'h0F && insn.modrm[5:3] != 3'h0
    |=> !dec.set_write && unrecognised)
    else $error("set byte accepted with nonzero reg field");
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !in_valid |=> !out_valid && dec.op == ssd_pkg::op_none)
    else $error("output without a request");

  // Set-byte destination and source
  a_set_reg_dest: assert property (@(posedge core_clk) disable iff (rst)
    s_set_any ##0 insn.modrm[7:6] == 2'h3
    |=> out_valid && dec.set_write && !dec.mem_dest)
    else $error("set byte to register decoded as memory");
  a_set_mem_dest: assert property (@(posedge core_clk) disable iff (rst)
    s_set_any ##0 insn.modrm[7:6] != 2'h3
    |=> out_valid && dec.set_write && dec.mem_dest)
    else $error("set byte to memory decoded as register");
  a_set_source: assert property (@(posedge core_clk) disable iff (rst)
    dec.set_write |-> $past(in_valid) && $past(insn.op0) == 8'h0F
      && $past(insn.modrm[5:3]) == 3'h0)
    else $error("set byte without a set-byte request");
  a_set_outside: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && insn.op0 == 8'h0F && insn.op1 inside {8'h90, 8'h98, 8'h99, 8'h9A, 8'h9B}
    |=> s_empty_ans)
    else $error("set-byte code outside this block accepted");
  a_set_code_only: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && insn.op0 == 8'h0F && insn.modrm[5:3] == 3'h0
      && !(insn.op1 inside {[8'h91:8'h97], [8'h9C:8'h9F]}) |=> s_empty_ans)
    else $error("unknown second byte accepted");

  // Requests that this block refuses
  a_unknown_zero: assert property (@(posedge core_clk) disable iff (rst)
    unrecognised |-> out_valid && dec == '0)
    else $error("unrecognised request left a decoded result");
  a_grp_other: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && (insn.op0 & 8'hFC) == 8'h80 && insn.modrm[5:3] != 3'h3
    |=> s_empty_ans)
    else $error("other immediate group member accepted");
  a_escape_borrow: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && insn.op0 == 8'h0F |=> !dec.writes_flags)
    else $error("two-byte opcode decoded as subtract-with-borrow");
  a_issue_known: assert property (@(posedge core_clk) disable iff (rst)
    out_valid && !unrecognised |-> dec.issue_clks == 4'h1)
    else $error("recognised request without one-clock issue");

  // Valid, hit and result kind
  a_valid_follows: assert property (@(posedge core_clk) disable iff (rst)
    in_valid |=> out_valid)
    else $error("request without an answer");
  a_hit_echo: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && cache_hit |=> hit)
    else $error("cache hit not reported");
  a_hit_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !(in_valid && cache_hit) |=> !hit)
    else $error("hit reported without a hit request");
  a_cache_only_hit: assert property (@(posedge core_clk) disable iff (rst)
    hit |-> out_valid)
    else $error("hit without an answer");
  a_one_kind: assert property (@(posedge core_clk) disable iff (rst)
    out_valid |-> $onehot({dec.set_write, dec.writes_flags, unrecognised}))
    else $error("answer has no single kind");
  a_idle_empty: assert property (@(posedge core_clk) disable iff (rst)
    !in_valid |=> !hit && !unrecognised && dec == '0)
    else $error("status without a request");
  a_borrow_no_set: assert property (@(posedge core_clk) disable iff (rst)
    dec.writes_flags |-> !dec.set_write && dec.set_value == 8'h00)
    else $error("flag writer also stores a set byte");

  // Synchronous reset clears every output
  a_reset_clears: assert property (@(posedge core_clk)
    rst |=> !out_valid && !hit && !unrecognised && dec == '0)
    else $error("outputs not cleared by reset");

endmodule

//--- tb/tb.sv
`timescale 1ns/100ps

module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic in_valid = 1'b0;
  ssd_pkg::ssd_insn_s insn = '0;
  logic cache_hit = 1'b0;
  ssd_pkg::ssd_flags_s flags = '0;
  logic out_valid;
  ssd_pkg::ssd_dec_s dec;
  logic hit;
  logic unrecognised;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;

  ssd_decode i_ssd_decode (
    .core_clk(core_clk), .rst(rst), .in_valid(in_valid), .insn(insn),
    .cache_hit(cache_hit), .flags(flags), .out_valid(out_valid), .dec(dec),
    .hit(hit), .unrecognised(unrecognised));

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, run needs a few hundred cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic ssd_pkg::ssd_dec_s mk(input ssd_pkg::ssd_op_e op, input logic md,
      input logic wf, input logic sw, input logic [7:0] sv);
    return {op, 4'h1, md, wf, sw, sv};
  endfunction

  // Request taken at next edge, answer checked just after that same edge
  task automatic req(input logic [23:0] i, input logic [3:0] f, input logic h,
      input ssd_pkg::ssd_dec_s e, input logic u);
    in_valid = 1'b1;
    insn = i;
    flags = f;
    cache_hit = h;
    @(posedge core_clk);
    #1;
    chk({31'h0, out_valid}, 32'h1);
    chk({12'h0, dec}, {12'h0, e});
    chk({30'h0, hit, unrecognised}, {30'h0, h, u});
  endtask

  task automatic idle();
    in_valid = 1'b0;
    @(posedge core_clk);
    #1;
    chk({9'h0, out_valid, hit, unrecognised, dec}, 32'h0);
  endtask

  function automatic logic cnd(input logic [7:0] b, input ssd_pkg::ssd_flags_s f);
    case (b)
      8'h92: return f.cf;
      8'h96: return f.cf | f.zf;
      8'h94: return f.zf;
      8'h9C: return f.sf != f.of_f;
      8'h9E: return f.zf | (f.sf != f.of_f);
      8'h93: return !f.cf;
      8'h97: return !f.cf & !f.zf;
      8'h95: return !f.zf;
      8'h9D: return f.sf == f.of_f;
      8'h9F: return !f.zf & (f.sf == f.of_f);
      default: return !f.of_f;
    endcase
  endfunction

  // Every code with every flag pattern, back to back, register and memory targets
  task automatic t_set_byte();
    logic [7:0] codes [11] = '{8'h92, 8'h96, 8'h94, 8'h9C, 8'h9E, 8'h93, 8'h97,
      8'h95, 8'h9D, 8'h9F, 8'h91};
    ssd_pkg::ssd_dec_s e;
    logic md;
    for (int k = 0; k < 11; k++) begin
      for (int f = 0; f < 16; f++) begin
        md = f[0];
        e = mk(ssd_pkg::ssd_op_e'(k + 6), md, 1'b0, 1'b1, {7'h0, cnd(codes[k], 4'(f))});
        req({8'h0F, codes[k], md ? 8'h05 : 8'hC1}, 4'(f), f[1], e, 1'b0);
      end
    end
    idle();
  endtask

  task automatic sb(input logic [23:0] i, input int k, input logic md, input logic h);
    req(i, 4'hA, h, mk(ssd_pkg::ssd_op_e'(k), md, 1'b1, 1'b0, 8'h00), 1'b0);
  endtask

  // Second byte set to a set-byte code to show it is ignored
  task automatic t_borrow();
    sb(24'h1894C8, 1, 1'b0, 1'b1);
    sb(24'h1A94D9, 1, 1'b0, 1'b0);
    sb(24'h199418, 2, 1'b1, 1'b1);
    sb(24'h1B9458, 3, 1'b0, 1'b1);
    sb(24'h8094D8, 4, 1'b0, 1'b0);
    sb(24'h839498, 4, 1'b1, 1'b1);
    sb(24'h1C9400, 5, 1'b0, 1'b1);
    sb(24'h1D9400, 5, 1'b0, 1'b0);
    idle();
  endtask

  task automatic t_refuse();
    req(24'h0F940D, 4'h4, 1'b1, '0, 1'b1);
    req(24'h0F90C0, 4'h8, 1'b1, '0, 1'b1);
    req(24'h0F9B05, 4'h0, 1'b0, '0, 1'b1);
    req(24'h80D8C0, 4'h1, 1'b1, '0, 1'b1);
    req(24'h1E0000, 4'h1, 1'b1, '0, 1'b1);
    req(24'h0F18C8, 4'h1, 1'b1, '0, 1'b1);
    idle();
  endtask

  // Reset in mid-run drops a pending request
  task automatic t_mid_reset();
    in_valid = 1'b1;
    insn = 24'h0F94C0;
    flags = 4'h2;
    rst = 1'b1;
    @(posedge core_clk);
    #1;
    chk({9'h0, out_valid, hit, unrecognised, dec}, 32'h0);
    rst = 1'b0;
    in_valid = 1'b0;
    @(posedge core_clk);
    #1;
    req(24'h0F94C0, 4'h2, 1'b1, mk(ssd_pkg::op_set_byte_equal, 1'b0, 1'b0, 1'b1, 8'h01),
      1'b0);
    idle();
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    idle();
    t_set_byte();
    t_borrow();
    t_refuse();
    t_mid_reset();
    give_verdict();
  end
endmodule
